/* File: adc_link_host.sv */
/*
  host end: drives select and serial clock, reads the 16-bit word.
  assumes the converter end shares ref_clk; sdo read with its enable.
*/
`timescale 1ns/1ps
module adc_link_host #(
  parameter int HALF_DIV = adc_seq_pkg::SCLK_HALF,
  parameter int QUIET_CYCLES = adc_seq_pkg::QUIET_CYCLES,
  parameter int WAKE_CYCLES = adc_seq_pkg::WAKE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  adc_link_if.host link,
  // user command
  input wire logic start,
  input wire logic [adc_seq_pkg::CNT_W-1:0] release_edges,
  input wire logic wake_wait,
  output logic ready,
  // user result
  output logic [adc_seq_pkg::RESULT_BITS-1:0] result,
  output logic result_valid
);
  typedef enum logic [1:0] {
    H_IDLE,
    H_SETUP,
    H_CLOCK,
    H_QUIET
  } host_state_t;
  host_state_t state_r;
  logic cs_r;
  logic sclk_r;
  logic [adc_seq_pkg::TMR_W-1:0] div_r;
  logic [adc_seq_pkg::TMR_W-1:0] quiet_r;
  logic [adc_seq_pkg::CNT_W-1:0] target_r;
  logic [adc_seq_pkg::CNT_W-1:0] falls_r;
  logic wake_r;
  logic [adc_seq_pkg::FRAME_BITS-1:0] shin_r;
  logic [adc_seq_pkg::RESULT_BITS-1:0] result_r;
  logic valid_r;
  logic tick;
  logic release_now;
  logic fall_now;
  assign tick = div_r == adc_seq_pkg::TMR_W'(HALF_DIV - 1);
  assign release_now = tick && sclk_r && falls_r == target_r
                       && (state_r == H_SETUP || state_r == H_CLOCK);
  assign fall_now = tick && sclk_r && falls_r != target_r
                    && (state_r == H_SETUP || state_r == H_CLOCK);
  // ********************************
  // sequencing
  // ********************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= H_IDLE;
      target_r <= adc_seq_pkg::CNT_ZERO;
      wake_r <= 1'b0;
    end else begin
      unique case (state_r)
        H_IDLE: begin
          if (start) begin
            state_r <= H_SETUP;
            target_r <= release_edges > adc_seq_pkg::LAST_EDGE ?
                        adc_seq_pkg::LAST_EDGE : release_edges;
            wake_r <= wake_wait;
          end
        end
        H_SETUP, H_CLOCK: begin
          if (release_now) begin
            state_r <= H_QUIET;
          end else if (fall_now) begin
            state_r <= H_CLOCK;
          end
        end
        H_QUIET: begin
          if (quiet_r == '0) begin
            state_r <= H_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || state_r == H_IDLE || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + adc_seq_pkg::TMR_W'(1);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      quiet_r <= '0;
    end else if (release_now) begin
      quiet_r <= wake_r ? adc_seq_pkg::TMR_W'(QUIET_CYCLES + WAKE_CYCLES)
                        : adc_seq_pkg::TMR_W'(QUIET_CYCLES);
    end else if (quiet_r != '0 && !link.sdo_oe) begin
      quiet_r <= quiet_r - adc_seq_pkg::TMR_W'(1);
    end
  end
  // ********************************
  // pins
  // ********************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_r <= 1'b1;
    end else if (state_r == H_IDLE && start) begin
      cs_r <= 1'b0;
    end else if (release_now) begin
      cs_r <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclk_r <= 1'b1;
    end else if (fall_now) begin
      sclk_r <= 1'b0;
    end else if (tick && !sclk_r) begin
      sclk_r <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (state_r == H_IDLE && start)) begin
      falls_r <= adc_seq_pkg::CNT_ZERO;
    end else if (fall_now) begin
      falls_r <= falls_r + adc_seq_pkg::CNT_ONE;
    end
  end
  // ********************************
  // receive
  // ********************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shin_r <= '0;
    end else if (fall_now) begin
      shin_r <= {shin_r[adc_seq_pkg::FRAME_BITS-2:0], link.sdo & link.sdo_oe};
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      result_r <= '0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= release_now && target_r == adc_seq_pkg::LAST_EDGE;
      if (release_now && target_r == adc_seq_pkg::LAST_EDGE) begin
        result_r <= shin_r[adc_seq_pkg::RESULT_BITS-1:0];
      end
    end
  end
  assign link.cs_n = cs_r;
  assign link.sclk = sclk_r;
  assign ready = state_r == H_IDLE;
  assign result = result_r;
  assign result_valid = valid_r;
endmodule

/* File: adc_link_if.sv */
/*
  serial link between converter and host: select, clock, data with enable.
  assumes the testbench resolves the shared data wire from sdo_oe.
*/
`timescale 1ns/1ps
interface adc_link_if;
  // ********************************
  // link signals
  // ********************************
  logic cs_n;
  logic sclk;
  logic sdo;
  logic sdo_oe;
  modport device (
    input cs_n,
    input sclk,
    output sdo,
    output sdo_oe
  );
  modport host (
    output cs_n,
    output sclk,
    input sdo,
    input sdo_oe
  );
endinterface

/* File: adc_power_mode_sequencer.sv */
/*
  converter end: frame counting, mode choice, result shifter, data enable.
  assumes cs_n and sclk arrive as pins and are synchronised here.
*/
// Overview of operation
// - select fall samples input, starts frame
// - host holds select past tenth edge
// - release edges ten to sixteen aborts, stays powered
// - sixteen clocks convert and read out
// - host waits quiet time after three-state
// - serial clock may idle high or low; select idles high (here the host idles sclk high and the checker flags a low idle clock)
// - normal, release two to ten: partial down
// - normal, release before two: stay normal
// - dummy frame held past ten powers up
// - dummy output invalid, powered after sixteen
// - partial, release before two: stay partial
// - partial, release two to ten: full down
// - three modes, chosen by release point
// - four zeros then twelve bits msb first
// - tracking resumes at thirteenth rising edge
// - host waits wake interval after full down
`timescale 1ns/1ps
module adc_power_mode_sequencer #(
  parameter int WAKE_CYCLES = adc_seq_pkg::WAKE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  adc_link_if.device link,
  // converter side
  input wire logic [adc_seq_pkg::RESULT_BITS-1:0] analog_code,
  output adc_seq_pkg::power_mode_t power_mode,
  output logic powering_up,
  output logic fully_powered,
  output logic tracking,
  output logic dummy_frame,
  output logic conv_done
);
  // ********************************
  // release window decode
  // ********************************
  function automatic adc_seq_pkg::release_win_t classify(
    input logic [adc_seq_pkg::CNT_W-1:0] cnt
  );
    if (cnt < adc_seq_pkg::PD_EDGE) begin
      classify = adc_seq_pkg::WIN_GLITCH;
    end else if (cnt < adc_seq_pkg::KEEP_EDGE) begin
      classify = adc_seq_pkg::WIN_POWER_DOWN;
    end else begin
      classify = adc_seq_pkg::WIN_KEEP;
    end
  endfunction

  // ********************************
  // pin synchronisers
  // ********************************
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_s3_r;
  logic sclk_s1_r;
  logic sclk_s2_r;
  logic sclk_s3_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      sclk_s1_r <= 1'b1;
      sclk_s2_r <= 1'b1;
      sclk_s3_r <= 1'b1;
    end else begin
      cs_s1_r <= link.cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      sclk_s1_r <= link.sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;
  logic in_frame;
  assign cs_fall = cs_s3_r & ~cs_s2_r;
  assign cs_rise = ~cs_s3_r & cs_s2_r;
  assign in_frame = ~cs_s2_r & ~cs_s3_r;
  assign sclk_fall = in_frame & sclk_s3_r & ~sclk_s2_r;
  assign sclk_rise = in_frame & ~sclk_s3_r & sclk_s2_r;

  // ********************************
  // edge counters
  // ********************************
  logic [adc_seq_pkg::CNT_W-1:0] fall_cnt_r;
  logic [adc_seq_pkg::CNT_W-1:0] rise_cnt_r;
  logic last_fall;
  assign last_fall = sclk_fall && (fall_cnt_r == adc_seq_pkg::LAST_EDGE - adc_seq_pkg::CNT_ONE);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fall_cnt_r <= adc_seq_pkg::CNT_ZERO;
    end else if (cs_fall) begin
      fall_cnt_r <= adc_seq_pkg::CNT_ZERO;
    end else if (sclk_fall && fall_cnt_r < adc_seq_pkg::LAST_EDGE) begin
      fall_cnt_r <= fall_cnt_r + adc_seq_pkg::CNT_ONE;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rise_cnt_r <= adc_seq_pkg::CNT_ZERO;
    end else if (cs_fall) begin
      rise_cnt_r <= adc_seq_pkg::CNT_ZERO;
    end else if (sclk_rise && rise_cnt_r < adc_seq_pkg::LAST_EDGE) begin
      rise_cnt_r <= rise_cnt_r + adc_seq_pkg::CNT_ONE;
    end
  end

  // ********************************
  // result shifter and data enable
  // ********************************
  logic [adc_seq_pkg::FRAME_BITS-1:0] shift_r;
  logic oe_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shift_r <= '0;
    end else if (cs_fall) begin
      shift_r <= {adc_seq_pkg::LEAD_VAL, analog_code};
    end else if (sclk_fall && fall_cnt_r < adc_seq_pkg::LAST_EDGE) begin
      shift_r <= {shift_r[adc_seq_pkg::FRAME_BITS-2:0], 1'b0};
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      oe_r <= 1'b0;
    end else if (cs_rise) begin
      oe_r <= 1'b0;
    end else if (cs_fall) begin
      oe_r <= 1'b1;
    end else if (last_fall) begin
      oe_r <= 1'b0;
    end
  end
  assign link.sdo = shift_r[adc_seq_pkg::FRAME_BITS-1];
  assign link.sdo_oe = oe_r;

  // ********************************
  // conversion complete and tracking
  // ********************************
  logic dummy_r;
  logic done_r;
  logic track_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      done_r <= 1'b0;
    end else begin
      done_r <= last_fall && !dummy_r;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      track_r <= 1'b1;
    end else if (cs_fall) begin
      track_r <= 1'b0;
    end else if (sclk_rise && rise_cnt_r == adc_seq_pkg::TRACK_RISE - adc_seq_pkg::CNT_ONE) begin
      track_r <= 1'b1;
    end else if (cs_rise) begin
      track_r <= 1'b1;
    end
  end

  // ********************************
  // power mode
  // ********************************
  adc_seq_pkg::power_mode_t mode_r;
  adc_seq_pkg::power_mode_t mode_nxt;
  adc_seq_pkg::release_win_t win;
  assign win = classify(fall_cnt_r);
  always_comb begin
    mode_nxt = mode_r;
    if (cs_rise) begin
      unique case (mode_r)
        adc_seq_pkg::MODE_NORMAL: begin
          if (win == adc_seq_pkg::WIN_POWER_DOWN) begin
            mode_nxt = adc_seq_pkg::MODE_PARTIAL_PD;
          end
        end
        adc_seq_pkg::MODE_PARTIAL_PD: begin
          if (win == adc_seq_pkg::WIN_POWER_DOWN) begin
            mode_nxt = adc_seq_pkg::MODE_FULL_PD;
          end else if (win == adc_seq_pkg::WIN_KEEP) begin
            mode_nxt = adc_seq_pkg::MODE_NORMAL;
          end
        end
        adc_seq_pkg::MODE_FULL_PD: begin
          if (win == adc_seq_pkg::WIN_KEEP) begin
            mode_nxt = adc_seq_pkg::MODE_NORMAL;
          end
        end
        default: begin
          mode_nxt = adc_seq_pkg::MODE_NORMAL;
        end
      endcase
    end else if (last_fall && mode_r != adc_seq_pkg::MODE_NORMAL) begin
      mode_nxt = adc_seq_pkg::MODE_NORMAL;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_r <= adc_seq_pkg::MODE_NORMAL;
    end else begin
      mode_r <= mode_nxt;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dummy_r <= 1'b0;
    end else if (cs_fall) begin
      dummy_r <= mode_r != adc_seq_pkg::MODE_NORMAL;
    end
  end

  // ********************************
  // power-up progress and wake timer
  // ********************************
  logic powering_r;
  logic [adc_seq_pkg::TMR_W-1:0] wake_r;
  logic full_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      powering_r <= 1'b0;
    end else if (cs_fall) begin
      powering_r <= mode_r != adc_seq_pkg::MODE_NORMAL;
    end else if (cs_rise || last_fall) begin
      powering_r <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wake_r <= '0;
    end else if (cs_fall && mode_r == adc_seq_pkg::MODE_FULL_PD) begin
      wake_r <= adc_seq_pkg::TMR_W'(WAKE_CYCLES);
    end else if (cs_rise && mode_r == adc_seq_pkg::MODE_FULL_PD
                 && win != adc_seq_pkg::WIN_KEEP) begin
      wake_r <= '0;
    end else if (wake_r != '0) begin
      wake_r <= wake_r - adc_seq_pkg::TMR_W'(1);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      full_r <= 1'b1;
    end else begin
      full_r <= mode_r == adc_seq_pkg::MODE_NORMAL && wake_r == '0;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign power_mode = mode_r;
  assign powering_up = powering_r;
  assign fully_powered = full_r;
  assign tracking = track_r;
  assign dummy_frame = dummy_r;
  assign conv_done = done_r;
endmodule

/* File: adc_power_mode_sequencer_bench.sv */
/*
  bench joining converter end and host end over the link interface.
  assumes a 125 MHz clock; host wake time shortened to HOST_WAKE.
*/
`timescale 1ns/1ps
module adc_power_mode_sequencer_bench;
  localparam int HOST_WAKE = 20;
  localparam adc_seq_pkg::power_mode_t NRM = adc_seq_pkg::MODE_NORMAL;
  localparam adc_seq_pkg::power_mode_t PPD = adc_seq_pkg::MODE_PARTIAL_PD;
  localparam adc_seq_pkg::power_mode_t FPD = adc_seq_pkg::MODE_FULL_PD;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [4:0] release_edges = 5'h00;
  logic wake_wait = 1'b0;
  logic [11:0] analog_code = 12'h000;
  adc_seq_pkg::power_mode_t power_mode;
  logic powering_up, fully_powered, tracking, dummy_frame, conv_done;
  logic ready, result_valid;
  logic [11:0] result;
  logic [15:0] word_r;
  logic seen_done, seen_valid, seen_dummy, seen_pu, trk13, trk15;
  int falls, hi_cnt, failures, num_checks;
  // ********************************
  // ends and checker
  // ********************************
  adc_link_if link ();
  adc_power_mode_sequencer #(.WAKE_CYCLES(4)) u_adc_power_mode_sequencer (
    .ref_clk(ref_clk), .rst_n(rst_n), .link(link), .analog_code(analog_code),
    .power_mode(power_mode), .powering_up(powering_up), .fully_powered(fully_powered),
    .tracking(tracking), .dummy_frame(dummy_frame), .conv_done(conv_done));
  adc_link_host #(.WAKE_CYCLES(HOST_WAKE)) u_adc_link_host (
    .ref_clk(ref_clk), .rst_n(rst_n), .link(link), .start(start),
    .release_edges(release_edges), .wake_wait(wake_wait), .ready(ready),
    .result(result), .result_valid(result_valid));
  adc_seq_chk u_adc_seq_chk (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .sdo(link.sdo), .sdo_oe(link.sdo_oe));
  // ********************************
  // clock and monitors
  // ********************************
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  always @(negedge link.sclk) begin
    if (link.cs_n === 1'b0) begin
      word_r = {word_r[14:0], link.sdo_oe ? link.sdo : ~link.sdo};
      falls++;
      if (falls == 13) trk13 = tracking;
      if (falls == 15) trk15 = tracking;
    end
  end
  always @(posedge ref_clk) begin
    hi_cnt = (link.cs_n === 1'b1) ? hi_cnt + 1 : 0;
    if (conv_done === 1'b1) seen_done = 1'b1;
    if (result_valid === 1'b1) seen_valid = 1'b1;
    if (dummy_frame === 1'b1) seen_dummy = 1'b1;
    if (powering_up === 1'b1) seen_pu = 1'b1;
  end
  // ********************************
  // compare and closing tasks
  // ********************************
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_mode(input adc_seq_pkg::power_mode_t exp);
    num_checks++;
    if (power_mode !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, power_mode, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ********************************
  // one frame through the host
  // ********************************
  task automatic frame(input logic [4:0] edges, input logic wake, input logic [11:0] code);
    int n;
    @(posedge ref_clk);
    start <= 1'b1;
    release_edges <= edges;
    wake_wait <= wake;
    analog_code <= code;
    #1;
    falls = 0;
    {seen_done, seen_valid, seen_dummy, seen_pu} = 4'h0;
    n = 0;
    @(posedge ref_clk);
    start <= 1'b0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (ready !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      failures++;
      wrap_up();
    end
    check_bit(falls == int'(edges), 1'b1);
    check_bit(hi_cnt >= 8 + (wake ? HOST_WAKE : 0), 1'b1);
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_normal();
    logic [11:0] code;
    for (int i = 0; i < 2; i++) begin
      code = i ? 12'h3a7 : 12'ha5c;
      frame(5'h10, 1'b0, code);
      check_word(word_r, {4'h0, code});
      check_word({4'h0, result}, {4'h0, code});
      check_bit(seen_valid, 1'b1);
      check_bit(seen_done, 1'b1);
      check_bit(trk13, 1'b0);
      check_bit(trk15, 1'b1);
      check_bit(seen_pu, 1'b0);
      check_mode(NRM);
    end
    $display("test normal done");
  endtask
  task automatic t_glitch_abort();
    frame(5'h01, 1'b0, 12'h111);
    check_mode(NRM);
    check_bit(seen_valid, 1'b0);
    for (int e = 10; e < 16; e += 5) begin
      frame(5'(e), 1'b0, 12'h222);
      check_mode(NRM);
      check_bit(seen_done | seen_valid, 1'b0);
    end
    $display("test glitch abort done");
  endtask
  task automatic t_partial();
    frame(5'h02, 1'b0, 12'h333);
    check_mode(PPD);
    check_bit(fully_powered, 1'b0);
    frame(5'h01, 1'b0, 12'h333);
    check_mode(PPD);
    check_bit(seen_pu, 1'b1);
    frame(5'h10, 1'b0, 12'h444);
    check_mode(NRM);
    check_bit(seen_dummy, 1'b1);
    check_bit(seen_done, 1'b0);
    frame(5'h09, 1'b0, 12'h555);
    check_mode(PPD);
    frame(5'h0c, 1'b0, 12'h555);
    check_mode(NRM);
    $display("test partial done");
  endtask
  task automatic t_full();
    frame(5'h05, 1'b0, 12'h666);
    frame(5'h09, 1'b0, 12'h666);
    check_mode(FPD);
    check_bit(fully_powered, 1'b0);
    frame(5'h01, 1'b0, 12'h666);
    check_mode(FPD);
    frame(5'h10, 1'b1, 12'h777);
    check_mode(NRM);
    check_bit(seen_dummy, 1'b1);
    check_bit(fully_powered, 1'b1);
    frame(5'h10, 1'b0, 12'h9c1);
    check_word({4'h0, result}, 16'h09c1);
    check_bit(seen_done, 1'b1);
    $display("test full done");
  endtask
  // ********************************
  // main sequence
  // ********************************
  initial begin
    {hi_cnt, falls, failures, num_checks} = '0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_normal();
    t_glitch_abort();
    t_partial();
    t_full();
    wrap_up();
  end
endmodule

/* File: adc_seq_chk.sv */
/*
  link checker: select, serial clock and data enable of the joined ends.
  assumes the bench places it beside the link interface, ports by name.
*/
`timescale 1ns/1ps
module adc_seq_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic sdo_oe
);
  // ********************************
  // falling-edge count in frame
  // ********************************
  logic sclk_q_r;
  logic [4:0] fall_cnt_r;
  always_ff @(posedge ref_clk) begin
    sclk_q_r <= sclk;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || cs_n) begin
      fall_cnt_r <= 5'h00;
    end else if (sclk_q_r && !sclk) begin
      fall_cnt_r <= fall_cnt_r + 5'h01;
    end
  end
  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence frame_open;
    $fell(cs_n) ##1 (!cs_n) [*5];
  endsequence
  sequence frame_close;
    $rose(cs_n);
  endsequence
  sequence last_fall;
    !cs_n && sclk_q_r && !sclk && fall_cnt_r == 5'h0f;
  endsequence
  oe_rise_a: assert property (frame_open |-> sdo_oe)
    else $error("data enable missing in frame");
  oe_drop_a: assert property (frame_close |-> ##[1:8] !sdo_oe)
    else $error("data enable kept after release");
  idle_oe_a: assert property (cs_n [*8] |-> !sdo_oe)
    else $error("data driven while idle");
  word_end_a: assert property (last_fall |-> ##[1:8] !sdo_oe)
    else $error("data enable kept after last bit");
  frame_len_a: assert property (fall_cnt_r <= 5'h10)
    else $error("too many clock falls in frame");
  idle_clock_a: assert property (cs_n |-> sclk)
    else $error("serial clock low while idle");
  quiet_gap_a: assert property (frame_close |-> cs_n [*8])
    else $error("select lowered inside quiet time");
  lead_zero_a: assert property (!cs_n && sdo_oe && fall_cnt_r < 5'h04 |-> !sdo)
    else $error("leading bit not zero");
endmodule

/* File: adc_seq_pkg.sv */
/*
  constants, modes and timing for the converter sequencer and its host.
  assumes one clock, ref_clk at 125 MHz, shared by both ends.
*/
package adc_seq_pkg;
  // ********************************
  // frame layout
  // ********************************
  localparam int FRAME_BITS = 16;
  localparam int RESULT_BITS = 12;
  localparam int LEAD_ZEROS = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] PD_EDGE = 5'h02;
  localparam logic [CNT_W-1:0] KEEP_EDGE = 5'h0a;
  localparam logic [CNT_W-1:0] TRACK_RISE = 5'h0d;
  localparam logic [CNT_W-1:0] LAST_EDGE = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [LEAD_ZEROS-1:0] LEAD_VAL = 4'h0;
  // ********************************
  // timing
  // ********************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int QUIET_NS = 60;
  localparam int FULL_WAKE_INTERVAL_NS = 1000;
  localparam int QUIET_CYCLES = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES =
    (FULL_WAKE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF = 4;
  localparam int TMR_W = 16;
  // ********************************
  // types
  // ********************************
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PARTIAL_PD,
    MODE_FULL_PD
  } power_mode_t;
  typedef enum logic [1:0] {
    WIN_GLITCH,
    WIN_POWER_DOWN,
    WIN_KEEP
  } release_win_t;
endpackage
